// ---- hdl/fph_device.sv ----
// device end: parameter mode, unlock, store command and parameter map
// Operation
// - mode request acknowledged by mode active bit
// - master presents index and value before strobe
// - strobe takes index and value; done on success
// - no done bit means write not applied
// - index 2100 stores set; value below 60000
// - writes refused until password written at 2200; here only while access_code_set is high
// - unlock lost when mode request drops
// - three bad passwords lock mode active off
// - lockout lasts until restart only
// - writes accepted and applied with axis enabled
// - master stores only when necessary
// - decel profile codes 1 to 3
// - extra signal selectors take codes 1 to 8
// - pressure gains used while pressure feedback active
// - write done is status byte 4 bit 6
// - mode active is status byte 4 bit 7
// - 32-bit readout returned high word first
//
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/1ns
module fph_device (
    input  wire logic  ref_clk,
    input  wire logic  rst_n,
    fph_link_if.dev    link,
    input  wire logic  access_code_set,
    input  wire logic [31:0] access_code,
    input  wire logic  pressure_fb_active,
    output      logic  store_request,
    output      logic  mode_active_status,
    output      logic  lockout,
    output      logic [31:0] gain_dir_a,
    output      logic [31:0] gain_dir_b,
    output      logic [1:0]  decel_profile,
    output      logic [3:0]  extra_signal_select_1,
    output      logic [3:0]  extra_signal_select_2
);
    // ----------------
    // state
    // ----------------
    typedef enum logic [1:0] {
        DEV_OFF,
        DEV_ON,
        DEV_LOCKED
    } fph_dev_state_t;

    typedef struct packed {
        fph_dev_state_t st;
        logic [1:0]     fails;
        logic           unlocked;
        logic           done;
        logic           strobe_q;
        logic           store;
        logic [31:0]    readout;
        logic [31:0]    gain_a;
        logic [31:0]    gain_b;
    } fph_dev_t;

    fph_dev_t s;
    fph_dev_t next_s;

    logic        wr_en;
    logic [5:0]  wr_slot;
    logic [5:0]  rd_slot;
    logic [31:0] rd_data;
    logic [31:0] g_a;
    logic [31:0] g_b;
    logic [31:0] g_ap;
    logic [31:0] g_bp;
    logic [31:0] prof;
    logic [31:0] sel1;
    logic [31:0] sel2;

    // ----------------
    // value checks for coded parameters
    // ----------------
    function automatic logic value_ok(input logic [5:0] slot, input logic [31:0] v);
        value_ok = 1'b1;
        if (slot == fph_pkg::SLOT_PROFILE) begin
            value_ok = v >= fph_pkg::PROFILE_LINEAR && v <= fph_pkg::ROOT_BRAKING_TWO;
        end
        if (slot == fph_pkg::SLOT_EXTRA_1 || slot == fph_pkg::SLOT_EXTRA_2) begin
            value_ok = v >= fph_pkg::EXTRA_NONE && v <= fph_pkg::ACTUAL_SPEED;
        end
    endfunction

    fph_param_store u_store (
        .ref_clk       (ref_clk),
        .rst_n         (rst_n),
        .wr_en         (wr_en),
        .wr_slot       (wr_slot),
        .wr_data       (link.param_value),
        .rd_slot       (rd_slot),
        .rd_data       (rd_data),
        .gain_a        (g_a),
        .gain_b        (g_b),
        .gain_a_pr     (g_ap),
        .gain_b_pr     (g_bp),
        .decel_profile (prof),
        .extra_sel_1   (sel1),
        .extra_sel_2   (sel2)
    );

    assign wr_slot = fph_pkg::slot_of(link.param_index);
    assign rd_slot = wr_slot;

    // ----------------
    // handshake
    // ----------------
    always_comb begin
        logic rise;
        logic allowed;
        rise    = link.write_strobe && !s.strobe_q;
        allowed = s.unlocked || !access_code_set;
        next_s          = s;
        wr_en           = 1'b0;
        next_s.store    = 1'b0;
        next_s.strobe_q = link.write_strobe;
        next_s.readout  = rd_data;
        // pressure feedback swaps in its own gain pair
        next_s.gain_a = pressure_fb_active ? g_ap : g_a;
        next_s.gain_b = pressure_fb_active ? g_bp : g_b;
        if (!link.write_strobe) begin
            next_s.done = 1'b0;
        end
        case (s.st)
            DEV_OFF: begin
                next_s.unlocked = 1'b0;
                next_s.done     = 1'b0;
                if (link.mode_request) begin
                    next_s.st = DEV_ON;
                end
            end
            DEV_ON: begin
                if (!link.mode_request) begin
                    next_s.st       = DEV_OFF;
                    next_s.unlocked = 1'b0;
                    next_s.done     = 1'b0;
                end else if (rise) begin
                    if (link.param_index == fph_pkg::IDX_UNLOCK) begin
                        if (!access_code_set || link.param_value == access_code) begin
                            next_s.unlocked = 1'b1;
                            next_s.done     = 1'b1;
                        end else begin
                            next_s.fails = s.fails + 2'h1;
                            if (s.fails + 2'h1 == fph_pkg::UNLOCK_TRIES) begin
                                next_s.st = DEV_LOCKED;
                            end
                        end
                    end else if (!allowed) begin
                        next_s.done = 1'b0;
                    end else if (link.param_index == fph_pkg::IDX_STORE) begin
                        // each store wears the nonvolatile memory, one pulse per strobe
                        if (link.param_value < fph_pkg::STORE_VALUE_LIMIT) begin
                            next_s.store = 1'b1;
                            next_s.done  = 1'b1;
                        end
                    end else if (wr_slot != fph_pkg::SLOT_NONE &&
                                 value_ok(wr_slot, link.param_value)) begin
                        // no gate on axis enable: changes act at once
                        wr_en       = 1'b1;
                        next_s.done = 1'b1;
                    end
                end
            end
            DEV_LOCKED: begin
                // only reset leaves this state
                next_s.unlocked = 1'b0;
                next_s.done     = 1'b0;
            end
            default: begin
                next_s.st = DEV_OFF;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // ----------------
    // outputs
    // ----------------
    always_comb begin
        link.status4                         = 8'h00;
        link.status4[fph_pkg::ST4_DONE_BIT]   = s.done;
        link.status4[fph_pkg::ST4_ACTIVE_BIT] = s.st == DEV_ON;
    end

    assign link.readout_hi           = s.readout[31:16];
    assign link.readout_lo           = s.readout[15:0];
    assign store_request             = s.store;
    assign mode_active_status        = s.st == DEV_ON;
    assign lockout                   = s.st == DEV_LOCKED;
    assign gain_dir_a                = s.gain_a;
    assign gain_dir_b                = s.gain_b;
    assign decel_profile             = prof[1:0];
    assign extra_signal_select_1     = sel1[3:0];
    assign extra_signal_select_2     = sel2[3:0];
endmodule

// ---- common/fph_pkg.sv ----
// constants shared by both ends of the parameter write handshake, and the slot lookup function used by the device end
package fph_pkg;
    // ----------------
    // parameter map
    // ----------------
    localparam int                NUM_SLOTS  = 34;
    localparam logic [5:0]        SLOT_NONE  = 6'h3F;
    localparam logic [15:0]       IDX_STORE  = 16'h2100;
    localparam logic [15:0]       IDX_UNLOCK = 16'h2200;
    localparam logic [15:0]       IDX_LIST [NUM_SLOTS] = '{
        16'h2000, 16'h2001, 16'h2002, 16'h2003, 16'h2010, 16'h2011, 16'h2012,
        16'h2013, 16'h2021, 16'h2022, 16'h2023, 16'h2024, 16'h2025, 16'h2026,
        16'h2040, 16'h2041, 16'h2042, 16'h2043, 16'h2050, 16'h2051, 16'h2052,
        16'h2053, 16'h2054, 16'h2055, 16'h2056, 16'h2057, 16'h2058, 16'h2059,
        16'h2070, 16'h2071, 16'h2074, 16'h2075, 16'h2076, 16'h2077};
    localparam logic [5:0]        SLOT_GAIN_A   = 6'h04;
    localparam logic [5:0]        SLOT_GAIN_B   = 6'h05;
    localparam logic [5:0]        SLOT_GAIN_AP  = 6'h06;
    localparam logic [5:0]        SLOT_GAIN_BP  = 6'h07;
    localparam logic [5:0]        SLOT_PROFILE  = 6'h08;
    localparam logic [5:0]        SLOT_EXTRA_1  = 6'h20;
    localparam logic [5:0]        SLOT_EXTRA_2  = 6'h21;
    // ----------------
    // codes and limits
    // ----------------
    localparam logic [31:0]       PROFILE_LINEAR     = 32'h0000_0001;
    localparam logic [31:0]       ROOT_BRAKING_ONE   = 32'h0000_0002;
    localparam logic [31:0]       ROOT_BRAKING_TWO   = 32'h0000_0003;
    localparam logic [31:0]       EXTRA_NONE         = 32'h0000_0001;
    localparam logic [31:0]       ACTUAL_SPEED       = 32'h0000_0008;
    localparam logic [31:0]       STORE_VALUE_LIMIT  = 32'h0000_EA60;
    localparam logic [1:0]        UNLOCK_TRIES       = 2'h3;
    localparam int                ST4_DONE_BIT       = 6;
    localparam int                ST4_ACTIVE_BIT     = 7;
    // ----------------
    // controller registers, byte offsets
    // ----------------
    localparam logic [4:0]        REG_CTRL      = 5'h00;
    localparam logic [4:0]        REG_INDEX     = 5'h04;
    localparam logic [4:0]        REG_VALUE     = 5'h08;
    localparam logic [4:0]        REG_STATUS    = 5'h0C;
    localparam logic [4:0]        REG_IRQ_STAT  = 5'h10;
    localparam logic [4:0]        REG_IRQ_CLR   = 5'h14;
    localparam logic [4:0]        REG_IRQ_EN    = 5'h18;
    localparam logic [4:0]        REG_READOUT   = 5'h1C;
    localparam int                IRQ_DONE      = 0;
    localparam int                IRQ_FAIL      = 1;
    localparam int                IRQ_LOST      = 2;
    localparam int                CLK_MHZ       = 50;
    localparam int                DONE_WAIT_NS  = 2000;
    localparam int                DONE_WAIT_CYC = DONE_WAIT_NS * CLK_MHZ / 1000;

    // map a parameter index to its storage slot
    function automatic logic [5:0] slot_of(input logic [15:0] idx);
        slot_of = SLOT_NONE;
        for (int i = 0; i < NUM_SLOTS; i++) begin
            if (IDX_LIST[i] == idx) begin
                slot_of = 6'(i);
            end
        end
    endfunction
endpackage

// ---- common/fph_link_if.sv ----
// cyclic process data exchanged between fieldbus master and device
`timescale 1ns/1ns
interface fph_link_if;
    logic        mode_request;
    logic        write_strobe;
    logic [15:0] param_index;
    logic [31:0] param_value;
    logic [7:0]  status4;
    logic [15:0] readout_hi;
    logic [15:0] readout_lo;

    modport dev  (input mode_request, write_strobe, param_index, param_value,
                  output status4, readout_hi, readout_lo);
    modport host (output mode_request, write_strobe, param_index, param_value,
                  input status4, readout_hi, readout_lo);
endinterface

// ---- hdl/fph_param_store.sv ----
// storage for the writable tuning parameters
`timescale 1ns/1ns
module fph_param_store #(
    parameter int SLOTS = fph_pkg::NUM_SLOTS
) (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        wr_en,
    input  wire logic [5:0]  wr_slot,
    input  wire logic [31:0] wr_data,
    input  wire logic [5:0]  rd_slot,
    output      logic [31:0] rd_data,
    output      logic [31:0] gain_a,
    output      logic [31:0] gain_b,
    output      logic [31:0] gain_a_pr,
    output      logic [31:0] gain_b_pr,
    output      logic [31:0] decel_profile,
    output      logic [31:0] extra_sel_1,
    output      logic [31:0] extra_sel_2
);
    typedef struct packed {
        logic [SLOTS-1:0][31:0] mem;
    } fph_store_t;

    fph_store_t s;
    fph_store_t next_s;

    always_comb begin
        next_s = s;
        if (wr_en && wr_slot < 6'(SLOTS)) begin
            next_s.mem[wr_slot] = wr_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign rd_data       = (rd_slot < 6'(SLOTS)) ? s.mem[rd_slot] : '0;
    assign gain_a        = s.mem[fph_pkg::SLOT_GAIN_A];
    assign gain_b        = s.mem[fph_pkg::SLOT_GAIN_B];
    assign gain_a_pr     = s.mem[fph_pkg::SLOT_GAIN_AP];
    assign gain_b_pr     = s.mem[fph_pkg::SLOT_GAIN_BP];
    assign decel_profile = s.mem[fph_pkg::SLOT_PROFILE];
    assign extra_sel_1   = s.mem[fph_pkg::SLOT_EXTRA_1];
    assign extra_sel_2   = s.mem[fph_pkg::SLOT_EXTRA_2];
endmodule

// ---- hdl/fph_master.sv ----
// master end: Avalon-MM registers driving the parameter handshake
`timescale 1ns/1ns
module fph_master #(
    parameter int WAIT_CYC = fph_pkg::DONE_WAIT_CYC
) (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    fph_link_if.host         link,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output      logic [31:0] avs_readdata,
    output      logic        avs_waitrequest,
    output      logic        irq
);
    typedef enum logic [1:0] {
        H_IDLE,
        H_SETUP,
        H_WAIT,
        H_REL
    } fph_host_state_t;

    typedef struct packed {
        fph_host_state_t st;
        logic            mode_req;
        logic [15:0]     idx;
        logic [31:0]     val;
        logic            strobe;
        logic [15:0]     cnt;
        logic            ack;
        logic [31:0]     rdata;
        logic            ok;
        logic            fail;
        logic            act_q;
        logic [2:0]      irq_st;
        logic [2:0]      irq_en;
    } fph_host_t;

    fph_host_t s;
    fph_host_t next_s;

    always_comb begin
        logic       go;
        logic       act;
        logic       dn;
        logic [2:0] ev;
        logic [2:0] clr;
        act    = link.status4[fph_pkg::ST4_ACTIVE_BIT];
        dn     = link.status4[fph_pkg::ST4_DONE_BIT];
        go     = 1'b0;
        ev     = 3'b000;
        clr    = 3'b000;
        next_s = s;
        next_s.ack   = 1'b0;
        next_s.act_q = act;
        // ----------------
        // bus slave: one wait cycle, then answer
        // ----------------
        if ((avs_read || avs_write) && !s.ack) begin
            next_s.ack = 1'b1;
            case (avs_address)
                fph_pkg::REG_CTRL:     next_s.rdata = {31'h0, s.mode_req};
                fph_pkg::REG_INDEX:    next_s.rdata = {16'h0, s.idx};
                fph_pkg::REG_VALUE:    next_s.rdata = s.val;
                fph_pkg::REG_STATUS:   next_s.rdata = {28'h0, s.fail, s.ok,
                                                       s.st != H_IDLE, act};
                fph_pkg::REG_IRQ_STAT: next_s.rdata = {29'h0, s.irq_st};
                fph_pkg::REG_IRQ_EN:   next_s.rdata = {29'h0, s.irq_en};
                fph_pkg::REG_READOUT:  next_s.rdata = {link.readout_hi, link.readout_lo};
                default:               next_s.rdata = 32'h0000_0000;
            endcase
        end
        if (s.ack && avs_write) begin
            case (avs_address)
                fph_pkg::REG_CTRL: begin
                    next_s.mode_req = avs_writedata[0];
                    go              = avs_writedata[1];
                end
                fph_pkg::REG_INDEX:   next_s.idx    = avs_writedata[15:0];
                fph_pkg::REG_VALUE:   next_s.val    = avs_writedata;
                fph_pkg::REG_IRQ_CLR: clr           = avs_writedata[2:0];
                fph_pkg::REG_IRQ_EN:  next_s.irq_en = avs_writedata[2:0];
                default: ;
            endcase
        end
        // ----------------
        // transfer sequence
        // ----------------
        case (s.st)
            H_IDLE: begin
                if (go) begin
                    next_s.ok   = 1'b0;
                    next_s.fail = 1'b0;
                    if (act) begin
                        next_s.st = H_SETUP;
                    end else begin
                        next_s.fail      = 1'b1;
                        ev[fph_pkg::IRQ_FAIL] = 1'b1;
                    end
                end
            end
            H_SETUP: begin
                // index and value have stood on the link a cycle already
                next_s.strobe = 1'b1;
                next_s.cnt    = '0;
                next_s.st     = H_WAIT;
            end
            H_WAIT: begin
                next_s.cnt = s.cnt + 16'h0001;
                if (dn) begin
                    next_s.ok     = 1'b1;
                    next_s.strobe = 1'b0;
                    next_s.st     = H_REL;
                    ev[fph_pkg::IRQ_DONE] = 1'b1;
                end else if (s.cnt >= 16'(WAIT_CYC - 1) || !act) begin
                    next_s.fail   = 1'b1;
                    next_s.strobe = 1'b0;
                    next_s.st     = H_REL;
                    ev[fph_pkg::IRQ_FAIL] = 1'b1;
                end
            end
            H_REL: begin
                if (!dn) begin
                    next_s.st = H_IDLE;
                end
            end
            default: begin
                next_s.st = H_IDLE;
            end
        endcase
        if (s.act_q && !act && s.mode_req) begin
            ev[fph_pkg::IRQ_LOST] = 1'b1;
        end
        // a new event wins over a clear in the same cycle
        next_s.irq_st = (s.irq_st & ~clr) | ev;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign link.mode_request = s.mode_req;
    assign link.write_strobe = s.strobe;
    assign link.param_index  = s.idx;
    assign link.param_value  = s.val;
    assign avs_readdata      = s.rdata;
    assign avs_waitrequest   = (avs_read || avs_write) && !s.ack;
    assign irq               = |(s.irq_st & s.irq_en);
endmodule

// ---- bench/fph_link_props.sv ----
// checker watching the link between the master and device ends
`timescale 1ns/1ns
module fph_link_props (
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic        mode_request,
    input wire logic        write_strobe,
    input wire logic [15:0] param_index,
    input wire logic [31:0] param_value,
    input wire logic [7:0]  status4,
    input wire logic [15:0] readout_hi,
    input wire logic [15:0] readout_lo
);
    // ----------------
    // helper state and sequences
    // ----------------
    logic seen_lock;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // active can only fall under a held request through lockout
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            seen_lock <= 1'b0;
        end else if (mode_request && $past(mode_request) && $fell(status4[7])) begin
            seen_lock <= 1'b1;
        end
    end
    sequence s_strobe_up; !write_strobe ##1 write_strobe; endsequence
    sequence s_bad_profile;
        s_strobe_up ##0 (param_index == 16'h2021 && !(param_value inside {[1:3]}));
    endsequence
    sequence s_bad_extra;
        s_strobe_up ##0 (param_index inside {16'h2076, 16'h2077}
            && !(param_value inside {[1:8]}));
    endsequence
    property p_ack; $rose(mode_request) && !seen_lock |=> status4[7]; endproperty
    a_ack: assert property (p_ack) else $error("mode active late");
    property p_drop; !mode_request |=> !status4[7] && !status4[6]; endproperty
    a_drop: assert property (p_drop) else $error("status without request");
    property p_done_cause;
        $rose(status4[6]) |-> $past(write_strobe) && $past(status4[7]);
    endproperty
    a_done_cause: assert property (p_done_cause) else $error("done without strobe");
    property p_done_clear; !write_strobe |=> !status4[6]; endproperty
    a_done_clear: assert property (p_done_clear) else $error("done stuck");
    property p_unmapped; s_strobe_up ##0 (param_index == 16'h2004) |=> !status4[6]; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped done");
    property p_store_lim;
        s_strobe_up ##0 (param_index == 16'h2100 && param_value >= 32'h0000_EA60)
        |=> !status4[6];
    endproperty
    a_store_lim: assert property (p_store_lim) else $error("store limit");
    property p_profile; s_bad_profile |=> !status4[6]; endproperty
    a_profile: assert property (p_profile) else $error("profile code");
    property p_extra; s_bad_extra |=> !status4[6]; endproperty
    a_extra: assert property (p_extra) else $error("extra select code");
    property p_locked; seen_lock |-> !status4[7] && !status4[6]; endproperty
    a_locked: assert property (p_locked) else $error("lockout left");
    property p_spare; status4[5:0] == 6'h00; endproperty
    a_spare: assert property (p_spare) else $error("spare status bits");
endmodule

// ---- bench/fph_tb_top.sv ----
// bench joining both ends, driving the master registers over avalon
`timescale 1ns/1ns
module fph_tb_top;
    // ----------------
    // signals, table and instances
    // ----------------
    typedef struct packed { logic [15:0] idx; logic [31:0] val; logic ok; } fph_row_t;
    logic        ref_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [4:0]  avs_address = 5'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        irq;
    logic        access_code_set = 1'b0;
    logic [31:0] access_code = 32'h5A3C_0001;
    logic        pressure_fb_active = 1'b0;
    logic        store_request, mode_active_status, lockout, irq_exp;
    logic [31:0] gain_dir_a, gain_dir_b, rd;
    logic [1:0]  decel_profile;
    logic [3:0]  extra_signal_select_1, extra_signal_select_2;
    logic [31:0] mem [logic [15:0]];
    int          err_total = 0;
    int          checked = 0;
    int          store_cnt = 0;
    localparam fph_row_t ROWS [18] = '{
        '{16'h2000, 32'h1234_5678, 1'b1}, '{16'h2010, 32'h0000_0111, 1'b1},
        '{16'h2012, 32'h0000_0222, 1'b1}, '{16'h2021, 32'h0000_0001, 1'b1},
        '{16'h2021, 32'h0000_0002, 1'b1}, '{16'h2021, 32'h0000_0004, 1'b0},
        '{16'h2021, 32'h0000_0000, 1'b0}, '{16'h2021, 32'h0000_0003, 1'b1},
        '{16'h2076, 32'h0000_0001, 1'b1}, '{16'h2076, 32'h0000_0009, 1'b0},
        '{16'h2077, 32'h0000_0000, 1'b0}, '{16'h2077, 32'h0000_0008, 1'b1},
        '{16'h2004, 32'h0000_0005, 1'b0}, '{16'h2100, 32'h0000_EA5F, 1'b1},
        '{16'h2100, 32'h0000_EA60, 1'b0}, '{16'h2200, 32'h0000_0000, 1'b1},
        '{16'h2059, 32'hFFFF_0001, 1'b1}, '{16'h2013, 32'h0000_0333, 1'b1}};
    fph_link_if fph_link_if_inst ();
    fph_device fph_device_inst (.ref_clk, .rst_n, .link(fph_link_if_inst), .access_code_set,
        .access_code, .pressure_fb_active, .store_request, .mode_active_status, .lockout,
        .gain_dir_a, .gain_dir_b, .decel_profile, .extra_signal_select_1,
        .extra_signal_select_2);
    fph_master #(.WAIT_CYC(10)) fph_master_inst (.ref_clk, .rst_n, .link(fph_link_if_inst),
        .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
        .irq);
    fph_link_props fph_link_props_inst (.ref_clk, .rst_n,
        .mode_request(fph_link_if_inst.mode_request),
        .write_strobe(fph_link_if_inst.write_strobe),
        .param_index(fph_link_if_inst.param_index),
        .param_value(fph_link_if_inst.param_value), .status4(fph_link_if_inst.status4),
        .readout_hi(fph_link_if_inst.readout_hi), .readout_lo(fph_link_if_inst.readout_lo));
    initial forever #10 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (store_request === 1'b1) store_cnt++;
    // ----------------
    // tasks
    // ----------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic complete_run();
        if (err_total == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic av(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0 && n < 40) begin
            @(posedge ref_clk);
            n++;
        end
        rd = avs_readdata;
        chk("bus answer", 32'h1, {31'h0, n < 40});
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic set_mode(input logic on);
        av(1'b1, fph_pkg::REG_CTRL, {31'h0, on});
        repeat (3) @(posedge ref_clk);
    endtask
    task automatic xfer(input logic [15:0] idx, input logic [31:0] val, input logic ok);
        int n;
        n = 0;
        av(1'b1, fph_pkg::REG_IRQ_CLR, 32'h0000_0007);
        chk("irq cleared", 32'h0, {31'h0, irq});
        av(1'b1, fph_pkg::REG_INDEX, {16'h0000, idx});
        av(1'b1, fph_pkg::REG_VALUE, val);
        av(1'b1, fph_pkg::REG_CTRL, 32'h0000_0003);
        rd = 32'h0;
        while (rd[1:0] === 2'b00 && n < 60) begin
            av(1'b0, fph_pkg::REG_IRQ_STAT, 32'h0);
            n++;
        end
        chk("transfer result", {30'h0, !ok, ok}, {30'h0, rd[1:0]});
        chk("irq line", {31'h0, irq_exp}, {31'h0, irq});
        if (ok && idx < 16'h2100) mem[idx] = val;
        repeat (3) @(posedge ref_clk);
        chk("readout", mem.exists(idx) ? mem[idx] : 32'h0,
            {fph_link_if_inst.readout_hi, fph_link_if_inst.readout_lo});
    endtask
    // ----------------
    // sequence of tests
    // ----------------
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_total++;
        complete_run();
    end
    initial begin
        irq_exp = 1'b1;
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        av(1'b1, fph_pkg::REG_IRQ_EN, 32'h0000_0003);
        set_mode(1'b1);
        av(1'b0, fph_pkg::REG_STATUS, 32'h0);
        chk("mode active", 32'h3, {30'h0, rd[0], mode_active_status});
        for (int i = 0; i < 18; i++) begin
            xfer(ROWS[i].idx, ROWS[i].val, ROWS[i].ok);
        end
        chk("store pulses", 32'h1, 32'(store_cnt));
        chk("profile", 32'h3, {30'h0, decel_profile});
        chk("extra select", 32'h81, {24'h0, extra_signal_select_2, extra_signal_select_1});
        chk("gain normal", mem[16'h2010], gain_dir_a);
        pressure_fb_active <= 1'b1;
        repeat (2) @(posedge ref_clk);
        chk("gain pressure", mem[16'h2012], gain_dir_a);
        chk("gain b pressure", mem[16'h2013], gain_dir_b);
        av(1'b1, fph_pkg::REG_IRQ_EN, 32'h0);
        irq_exp = 1'b0;
        xfer(16'h2001, 32'h0000_0042, 1'b1);
        access_code_set <= 1'b1;
        set_mode(1'b0);
        set_mode(1'b1);
        xfer(16'h2002, 32'h0000_0007, 1'b0);
        xfer(16'h2200, access_code, 1'b1);
        xfer(16'h2002, 32'h0000_0007, 1'b1);
        set_mode(1'b0);
        set_mode(1'b1);
        xfer(16'h2003, 32'h0000_0009, 1'b0);
        xfer(16'h2200, ~access_code, 1'b0);
        xfer(16'h2200, ~access_code, 1'b0);
        chk("lockout early", 32'h0, {31'h0, lockout});
        xfer(16'h2200, access_code, 1'b1);
        xfer(16'h2200, 32'h0000_0000, 1'b0);
        chk("lockout", 32'h1, {31'h0, lockout});
        av(1'b0, fph_pkg::REG_IRQ_STAT, 32'h0);
        chk("lost and fail", 32'h6, rd);
        av(1'b0, fph_pkg::REG_STATUS, 32'h0);
        chk("mode active locked", 32'h0, {30'h0, rd[0], mode_active_status});
        set_mode(1'b0);
        set_mode(1'b1);
        xfer(16'h2200, access_code, 1'b0);
        rst_n <= 1'b0;
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        mem.delete();
        chk("lockout after restart", 32'h0, {31'h0, lockout});
        av(1'b1, fph_pkg::REG_IRQ_EN, 32'h0000_0003);
        irq_exp = 1'b1;
        set_mode(1'b1);
        xfer(16'h2200, access_code, 1'b1);
        complete_run();
    end
endmodule
